// ===== logic/ues_pkg.sv
// Purpose: Constants and types for the uncorrectable error severity bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Severity bit positions match the error status bit positions
package ues_pkg;
    localparam logic [11:0] OFF_SEV = 12'h10c;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h204;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h208;
    localparam logic [11:0] OFF_ROUTE = 12'h20c;
    localparam int BIT_RESET_TIMEOUT = 21;
    localparam int BIT_UNSUPPORTED = 20;
    localparam int BIT_MALFORMED = 18;
    localparam int BIT_RX_OVERFLOW = 17;
    localparam int BIT_UNEXP_CPL = 16;
    localparam int BIT_CPL_ABORT = 15;
    localparam int BIT_CPL_TIMEOUT = 14;
    localparam int BIT_FLOW_CTRL = 13;
    localparam int BIT_POISONED = 12;
    localparam int BIT_SURPRISE_DOWN = 5;
    localparam int BIT_LINK_PROTO = 4;
    localparam int BIT_TRAINING = 0;
    // Writable bits, hub-link port and root port
    localparam logic [31:0] HUB_WMASK = 32'h0037f031;
    localparam logic [31:0] ROOT_WMASK = 32'h0017f031;
    // Power-on defaults
    localparam logic [31:0] HUB_RESET = 32'h00262011;
    localparam logic [31:0] ROOT_RESET = 32'h00062011;
    // Interrupt status bits
    localparam int IRQ_FATAL = 0;
    localparam int IRQ_NONFATAL = 1;
    localparam logic [1:0] IRQ_MASK = 2'h3;
    typedef struct packed {
        logic [31:0] fatal;
        logic [31:0] nonfatal;
    } ues_route_t;
endpackage : ues_pkg

// ===== logic/ues_severity.sv
// Purpose: Per-port severity register steering logged uncorrectable errors
// Assumes: APB slave; error events arrive as one-cycle pulses on err_log
// Notes: srst is the warm reset; por_rst alone restores severity defaults
// Behaviour
// RQ1: A logged error whose severity bit is one is routed as fatal.
// RQ2: A logged error whose severity bit is zero is routed as non-fatal.
// RQ3: Severity steers each logged error to the fatal or non-fatal first/next logs.
// RQ4: Only the hub-link port has reset time-out severity at bit 21, default one.
// RQ5: Unsupported request severity sits at bit 20, default zero.
// RQ6: Malformed packet severity sits at bit 18, default one.
// RQ7: Receiver overflow severity sits at bit 17, default one.
// RQ8: Unexpected completion severity sits at bit 16, default zero.
// RQ9: Completer abort severity sits at bit 15, default zero.
// RQ10: Completion time-out severity sits at bit 14, default zero.
// RQ11: Flow control error severity sits at bit 13, default one.
// RQ12: Poisoned packet severity sits at bit 12, default zero.
// RQ13: Surprise down severity sits at bit 5, default zero.
// RQ14: Link protocol error severity sits at bit 4, default one.
// RQ15: Software leaves training error severity at bit 0 alone.
// RQ16: The root-port variant uses the same offset and layout less bit 21.
// RQ17: Severity bits are sticky over warm reset; reserved bits read zero.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ues_severity #(
    parameter bit HUB_PORT = 1'b1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic por_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] err_log,
    output var ues_pkg::ues_route_t route,
    output logic irq
);
    localparam logic [31:0] WMASK = HUB_PORT ? ues_pkg::HUB_WMASK : ues_pkg::ROOT_WMASK;
    localparam logic [31:0] RESET = HUB_PORT ? ues_pkg::HUB_RESET : ues_pkg::ROOT_RESET;

    logic [31:0] sev;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [31:0] events;
    logic acc;
    logic wr;
    logic mapped;
    logic [31:0] next_rdata;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign pready = 1'b1;
    // Reserved bits never reach the routing
    assign events = err_log & WMASK; // RQ17

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h00000000;
        case (paddr)
            ues_pkg::OFF_SEV: next_rdata = sev; // RQ16
            ues_pkg::OFF_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
            ues_pkg::OFF_IRQ_CLEAR: next_rdata = 32'h00000000;
            ues_pkg::OFF_IRQ_ENABLE: next_rdata = {30'h00000000, irq_enable};
            ues_pkg::OFF_ROUTE: next_rdata = route.fatal;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = acc & ~mapped;

    // Read data latched in the setup cycle; status changing in the access cycle shows next read
    always_ff @(posedge mclk) begin
        if (srst || por_rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= next_rdata; // RQ16
        end
    end

    // Sticky store: warm reset leaves it alone
    always_ff @(posedge mclk) begin
        if (por_rst) begin
            sev <= RESET; // RQ4 RQ5 RQ6 RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14 RQ17
        end else if (wr && paddr == ues_pkg::OFF_SEV) begin
            sev <= pwdata & WMASK; // RQ16 RQ17
        end
    end

    // Routing registered so data outputs come from flip-flops
    always_ff @(posedge mclk) begin
        if (srst || por_rst) begin
            route <= '0;
        end else begin
            route.fatal <= events & sev; // RQ1 RQ3
            route.nonfatal <= events & ~sev; // RQ2 RQ3
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || por_rst) begin
            irq_enable <= 2'h0;
        end else if (wr && paddr == ues_pkg::OFF_IRQ_ENABLE) begin
            irq_enable <= pwdata[1:0] & ues_pkg::IRQ_MASK;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (srst || por_rst) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (irq_status
                & ~((wr && paddr == ues_pkg::OFF_IRQ_CLEAR) ? pwdata[1:0] : 2'h0))
                | {|(events & ~sev), |(events & sev)};
        end
    end

    assign irq = |(irq_status & irq_enable);

    property p_fatal_route;
        @(posedge mclk) disable iff (srst || por_rst)
        (|(events & sev)) |=> (route.fatal == $past(events & sev));
    endproperty
    a_fatal_route: assert property (p_fatal_route) else $error("fatal route wrong"); // RQ1

    property p_nonfatal_route;
        @(posedge mclk) disable iff (srst || por_rst)
        (|(events & ~sev)) |=> (|route.nonfatal) && ((route.nonfatal & route.fatal) == 32'h0);
    endproperty
    a_nonfatal_route: assert property (p_nonfatal_route) else $error("nonfatal route wrong"); // RQ2

    property p_route_split;
        @(posedge mclk) disable iff (srst || por_rst)
        ##1 ((route.fatal | route.nonfatal) == $past(events));
    endproperty
    a_route_split: assert property (p_route_split) else $error("log steering lost event"); // RQ3

    property p_por_defaults;
        @(posedge mclk) por_rst |=> (sev == RESET);
    endproperty
    a_por_defaults: assert property (p_por_defaults) else $error("severity default wrong"); // RQ6

    property p_hub_bit;
        @(posedge mclk) disable iff (por_rst)
        HUB_PORT == 1'b0 |-> sev[ues_pkg::BIT_RESET_TIMEOUT] == 1'b0;
    endproperty
    a_hub_bit: assert property (p_hub_bit) else $error("root port bit 21 set"); // RQ4

    property p_sticky;
        @(posedge mclk) disable iff (por_rst)
        (srst && !wr) |=> (sev == $past(sev));
    endproperty
    a_sticky: assert property (p_sticky) else $error("severity lost on warm reset"); // RQ17

    property p_reserved_zero;
        @(posedge mclk) disable iff (por_rst)
        (sev & ~WMASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RQ17

    property p_write_takes;
        @(posedge mclk) disable iff (por_rst)
        (wr && paddr == ues_pkg::OFF_SEV) |=> (sev == ($past(pwdata) & WMASK));
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("severity write lost"); // RQ16

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    property p_read_holds;
        @(posedge mclk) disable iff (srst || por_rst)
        s_setup ##1 s_access |-> (prdata == $past(next_rdata));
    endproperty
    a_read_holds: assert property (p_read_holds) else $error("read data not held"); // RQ16

    property p_fatal_flag;
        @(posedge mclk) disable iff (srst || por_rst)
        (|(events & sev)) |=> irq_status[ues_pkg::IRQ_FATAL];
    endproperty
    a_fatal_flag: assert property (p_fatal_flag) else $error("fatal flag not set"); // RQ1

    property p_nonfatal_flag;
        @(posedge mclk) disable iff (srst || por_rst)
        (|(events & ~sev)) |=> irq_status[ues_pkg::IRQ_NONFATAL];
    endproperty
    a_nonfatal_flag: assert property (p_nonfatal_flag) else $error("nonfatal flag not set"); // RQ2

    property p_unmapped_keeps;
        @(posedge mclk) disable iff (por_rst)
        (wr && !mapped) |=> (sev == $past(sev));
    endproperty
    a_unmapped_keeps: assert property (p_unmapped_keeps) else $error("unmapped write landed"); // RQ17

    property p_warm_clears;
        @(posedge mclk) disable iff (por_rst)
        srst |=> (irq_status == 2'h0) && (route == '0);
    endproperty
    a_warm_clears: assert property (p_warm_clears) else $error("warm reset left state"); // RQ3
endmodule // ues_severity
`default_nettype wire

// ===== verif/ues_bench.sv
// Purpose: Bench for the severity bank, hub and root variants on one bus
// Assumes: Zero-wait APB; route pulses one cycle after err_log
// Notes: Shared bus keeps it short; root bit 21 compared beside hub
`timescale 1ns/1ps
`default_nettype none
module uncorrectable_error_severity_bench;
    logic mclk = 0, srst = 1, por_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, err_log = '0, rd_h, rd_r, rh, rr;
    logic pready, pslverr, irq, rdy_r, perr, irq_r, slverr_r, perr_r;
    ues_pkg::ues_route_t route, route_r;
    int failures = 0, n_checks = 0;
    always #25 mclk = ~mclk;
    ues_severity #(.HUB_PORT(1'b1)) i_ues_severity (.mclk(mclk), .srst(srst),
        .por_rst(por_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(rd_h), .pready(pready), .pslverr(pslverr),
        .err_log(err_log), .route(route), .irq(irq));
    ues_severity #(.HUB_PORT(1'b0)) i_ues_severity_root (.mclk(mclk), .srst(srst),
        .por_rst(por_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(rd_r), .pready(rdy_r), .pslverr(slverr_r),
        .err_log(err_log), .route(route_r), .irq(irq_r));
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until pready and rdy_r are both seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 || rdy_r !== 1'b1);
        rh = rd_h;
        rr = rd_r;
        perr = pslverr;
        perr_r = slverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        repeat (2000) @(posedge mclk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, ues_pkg::OFF_SEV, 32'h0);
        chk(rh, 32'h00262011);
        chk(rr, 32'h00062011);
        apb(1'b1, ues_pkg::OFF_SEV, 32'hffffffff);
        apb(1'b0, ues_pkg::OFF_SEV, 32'h0);
        chk(rh, 32'h0037f031);
        chk(rr, 32'h0017f031);
        apb(1'b1, ues_pkg::OFF_SEV, 32'h0000f021);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, ues_pkg::OFF_SEV, 32'h0);
        chk(rh, 32'h0000f021);
        chk(rr, 32'h0000f021);
        apb(1'b1, ues_pkg::OFF_IRQ_ENABLE, 32'h1);
        apb(1'b0, ues_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk(rh, 32'h1);
        err_log <= 32'h0037f031;
        @(posedge mclk);
        err_log <= '0;
        @(negedge mclk);
        chk(route.fatal, 32'h0000f021);
        chk(route.nonfatal, 32'h00370010);
        chk(route_r.fatal, 32'h0000f021);
        chk(route_r.nonfatal, 32'h00170010);
        @(posedge mclk);
        apb(1'b0, ues_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(rh, 32'h3);
        chk({30'h0, irq_r, irq}, 32'h3);
        apb(1'b1, ues_pkg::OFF_IRQ_CLEAR, 32'h1);
        apb(1'b0, ues_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(rh, 32'h2);
        chk({30'h0, irq_r, irq}, 32'h0);
        apb(1'b0, ues_pkg::OFF_IRQ_CLEAR, 32'h0);
        chk(rh, 32'h0);
        apb(1'b0, ues_pkg::OFF_ROUTE, 32'h0);
        chk(rh, 32'h0);
        apb(1'b0, 12'h300, 32'h0);
        chk({perr, perr_r, rh[29:0]}, 32'hc0000000);
        por_rst <= 1'b1;
        @(posedge mclk);
        por_rst <= 1'b0;
        apb(1'b0, ues_pkg::OFF_SEV, 32'h0);
        chk(rh, 32'h00262011);
        chk(rr, 32'h00062011);
        print_verdict();
    end
endmodule // uncorrectable_error_severity_bench
`default_nettype wire
